/* File: design/adlp_top.sv */
// Converter control: registers, triggers, low-power modes, interrupt
// Assumes a plain register port on MCLK; trigger and comparator are pins
`timescale 1ns/1ps
`include "adlp_map.svh"
module adlp_top import adlp_pkg::*; #(
    parameter int         DIV_W    = 12,
    parameter logic [11:0] DIV_BASE = 12'h002
) (
    input  wire logic       MCLK,
    input  wire logic       SRST,
    input  wire logic [2:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    output logic            IRQ,
    input  wire logic       WAIT_MODE,
    input  wire logic       STOP_MODE,
    input  wire logic       HW_TRIG,
    input  wire logic       COMP,
    output logic     [10:0] DAC,
    output logic            SAMPLE,
    output logic            ANALOG_ON,
    output logic      [4:0] CH_SEL,
    output logic            ISOLATE
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    adlp_sar_if sar ();

    logic       ien_q;
    logic       cont_q;
    logic [4:0] ch_q;
    logic [7:0] cfg_q;
    logic       conversion_complete_flag_q;
    logic [9:0] res_q;
    logic       blk_q;
    logic [1:0] ist_q;
    logic [1:0] imsk_q;
    logic       trg_s1;
    logic       trg_s2;
    logic       trg_s3;
    logic       tick;
    logic       sc_wr;
    logic       cfg_wr;
    logic       rl_rd;
    logic       rh_rd;
    logic       halt;
    logic       go_ok;
    logic       trg_go;
    logic       xfer;
    logic       lost;
    logic [7:0] rd_mux;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    assign sc_wr  = WR && ADDR == `ADLP_OFF_SC;
    assign cfg_wr = WR && ADDR == `ADLP_OFF_CFG;
    assign rl_rd  = RD && ADDR == `ADLP_OFF_RL;
    assign rh_rd  = RD && ADDR == `ADLP_OFF_RH;

    // Bus clock stop without the private clock kills the conversion
    assign halt   = STOP_MODE && !cfg_q[`ADLP_CFG_ACLK]; // RL7
    assign go_ok  = !halt; // RL9
    // A transfer is blocked while a high-then-low result read is open
    assign xfer   = sar.done && !blk_q;
    assign lost   = sar.done && blk_q;
    assign trg_go = trg_s2 && !trg_s3 && cfg_q[`ADLP_CFG_EXT] && !sar.busy; // RL10

    always_comb begin
        sar.start = 1'b0;
        if (go_ok) begin
            if (sc_wr) begin
                sar.start = !ch_off(WDATA[4:0]) && !cfg_q[`ADLP_CFG_EXT]; // RL12
            end else if (!ch_off(ch_q) && !cfg_wr) begin
                sar.start = trg_go || (sar.done && (cont_q || blk_q)); // RL10
            end
        end
    end

    assign sar.abort    = sc_wr || cfg_wr || halt || ch_off(ch_q); // RL12 RL14
    assign sar.long_smp = cfg_q[`ADLP_CFG_LSMP];

    // ----------------------------------------
    // Engine and divider
    // ----------------------------------------
    adlp_clkdiv #(
        .CW   (DIV_W),
        .BASE (DIV_BASE)
    ) u_div (
        .clk    (MCLK),
        .srst   (SRST),
        .run    (sar.busy || sar.start),
        .div    (cfg_q[`ADLP_CFG_DIV]),
        .tick_q (tick)
    );

    adlp_sar u_sar (
        .clk      (MCLK),
        .srst     (SRST),
        .tick     (tick),
        .comp_in  (COMP),
        .ifc      (sar),
        .sample_q (SAMPLE),
        .dac_q    (DAC)
    );

    // ----------------------------------------
    // Trigger synchroniser
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            trg_s1 <= 1'b0;
            trg_s2 <= 1'b0;
            trg_s3 <= 1'b0;
        end else begin
            trg_s1 <= HW_TRIG;
            trg_s2 <= trg_s1;
            trg_s3 <= trg_s2;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ien_q  <= 1'(`ADLP_SC_RST >> `ADLP_SC_IEN);
            cont_q <= 1'(`ADLP_SC_RST >> `ADLP_SC_CONT);
            ch_q   <= 5'(`ADLP_SC_RST);
        end else if (sc_wr) begin
            ien_q  <= WDATA[`ADLP_SC_IEN];
            cont_q <= WDATA[`ADLP_SC_CONT];
            ch_q   <= WDATA[4:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cfg_q <= `ADLP_CFG_RST;
        end else if (cfg_wr) begin
            cfg_q <= WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            imsk_q <= 2'h0;
        end else if (WR && ADDR == `ADLP_OFF_IMSK) begin
            imsk_q <= WDATA[1:0];
        end
    end

    // ----------------------------------------
    // Result and completion flag
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            res_q <= 10'h000;
        end else if (xfer) begin
            res_q <= sar.result; // RL8
        end
    end

    // Reading the high byte holds off a new result until the low byte
    always_ff @(posedge MCLK) begin
        if (SRST || rl_rd || sc_wr) begin
            blk_q <= 1'b0;
        end else if (rh_rd) begin
            blk_q <= 1'b1;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            conversion_complete_flag_q <= 1'b0;
        end else if (xfer) begin
            conversion_complete_flag_q <= 1'b1; // RL3
        end else if (sc_wr || rl_rd) begin
            conversion_complete_flag_q <= 1'b0; // RL13
        end
    end

    // ----------------------------------------
    // Interrupt status and output
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ist_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (i == `ADLP_IST_DONE && xfer) begin
                    ist_q[i] <= 1'b1;
                end else if (i == `ADLP_IST_ABRT && halt && sar.busy) begin
                    ist_q[i] <= 1'b1;
                end else if (WR && ADDR == `ADLP_OFF_IST && WDATA[i]) begin
                    ist_q[i] <= 1'b0;
                end
            end
        end
    end

    // Held as long as the flag stays set, wait or stop alike
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= (conversion_complete_flag_q && ien_q) || |(ist_q & imsk_q); // RL4 RL5 RL15
        end
    end

    // ----------------------------------------
    // Analog controls
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ANALOG_ON <= 1'b0;
            CH_SEL    <= 5'(`ADLP_SC_RST);
            ISOLATE   <= 1'b1;
        end else begin
            ANALOG_ON <= sar.busy; // RL6
            CH_SEL    <= ch_q;
            ISOLATE   <= ch_off(ch_q); // RL14
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_comb begin
        unique case (ADDR)
            `ADLP_OFF_SC:   rd_mux = {conversion_complete_flag_q, ien_q, cont_q, ch_q};
            `ADLP_OFF_CFG:  rd_mux = cfg_q;
            `ADLP_OFF_RH:   rd_mux = {6'h00, res_q[9:8]};
            `ADLP_OFF_RL:   rd_mux = res_q[7:0];
            `ADLP_OFF_IST:  rd_mux = {6'h00, ist_q};
            `ADLP_OFF_IMSK: rd_mux = {6'h00, imsk_q};
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= RD ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);

    AST_CONVERSION_COMPLETE_FLAG_SET: assert property (xfer |=> conversion_complete_flag_q) // RL3
        else $error("flag not set at conversion end");
    AST_IRQ_RISE: assert property ($rose(conversion_complete_flag_q) && ien_q |=> IRQ) // RL4
        else $error("interrupt missing on completion");
    AST_WAIT_RUN: assert property ( // RL5
        WAIT_MODE && !STOP_MODE && !WR && sar.busy |-> !sar.abort)
        else $error("wait mode disturbed conversion");
    AST_SINGLE_OFF: assert property ( // RL6
        xfer && !cont_q && !trg_go && !WR |=> !sar.busy ##1 !ANALOG_ON)
        else $error("single conversion left converter on");
    AST_STOP_ABORT: assert property (halt |=> !sar.busy) // RL7
        else $error("stop did not abort");
    AST_RES_HOLD: assert property (!$stable(res_q) |-> $past(xfer)) // RL8
        else $error("result changed without completion");
    AST_STOP_ASYNC: assert property ( // RL9
        STOP_MODE && cfg_q[`ADLP_CFG_ACLK] && sar.busy && !WR && !ch_off(ch_q)
        |-> !sar.abort)
        else $error("async stop disturbed conversion");
    AST_TRIG_GO: assert property ( // RL10
        trg_go && go_ok && !WR && !ch_off(ch_q) |=> sar.busy)
        else $error("trigger did not start conversion");
    AST_SC_START: assert property ( // RL12
        sc_wr && go_ok && !ch_off(WDATA[4:0]) && !cfg_q[`ADLP_CFG_EXT] |=> sar.busy)
        else $error("control write did not start");
    AST_CONVERSION_COMPLETE_FLAG_CLR: assert property ((sc_wr || rl_rd) && !xfer |=> !conversion_complete_flag_q) // RL13
        else $error("flag not cleared");
    // A control write in the same cycle may legally turn the converter back on
    AST_OFF_ISO: assert property (ch_off(ch_q) && !sc_wr |=> ISOLATE && !sar.busy) // RL14
        else $error("channel off not isolated");
    AST_IRQ_HOLD: assert property (conversion_complete_flag_q && ien_q |=> IRQ) // RL15
        else $error("interrupt dropped early");

    CV_DONE:  cover property (xfer ##1 IRQ);
    CV_LOST:  cover property (lost);
    CV_HALT:  cover property (halt && sar.busy);
    CV_TRIG:  cover property (STOP_MODE && trg_go ##[1:200] xfer);
endmodule // adlp_top

/* File: inc/adlp_map.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the converter control modules only
//
// Summary of operation
// (RL1) Sample 3.5 or 23.5 converter clocks
// (RL2) Round 11-bit approximation to 1024 codes
// (RL3) Complete flag set at every conversion end; not set for one lost to an open result read
// (RL4) Enabled interrupt raised when flag sets
// (RL5) Wait mode keeps converting and interrupting
// (RL6) Single conversion ends in low power
// (RL7) Stop without async clock aborts conversion
// (RL8) Restart needs control write; result kept
// (RL9) Stop with async clock keeps converting
// (RL10) Stop with trigger mode waits for trigger
// (RL11) Software clears continuous before wait
// (RL12) Control write aborts, restarts unless off; the code also does not restart in trigger mode
// (RL13) Flag cleared by control write, low read
// (RL14) Channel all ones powers off, isolates
// (RL15) Interrupt held until flag cleared
`ifndef ADLP_MAP_SVH
`define ADLP_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADLP_OFF_SC    3'h0
`define ADLP_OFF_CFG   3'h1
`define ADLP_OFF_RH    3'h2
`define ADLP_OFF_RL    3'h3
`define ADLP_OFF_IST   3'h4
`define ADLP_OFF_IMSK  3'h5

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ADLP_SC_IEN    6
`define ADLP_SC_CONT   5
`define ADLP_CFG_LSMP  0
`define ADLP_CFG_ACLK  1
`define ADLP_CFG_EXT   2
`define ADLP_CFG_DIV   4:3
`define ADLP_IST_DONE  0
`define ADLP_IST_ABRT  1
`define ADLP_CH_OFF    5'h1f
`define ADLP_SC_RST    8'h1f
`define ADLP_CFG_RST   8'h00

// ----------------------------------------
// Sample window in converter half-cycles, and top raw code
// ----------------------------------------
`define ADLP_SMP_SHORT 6'h07
`define ADLP_SMP_LONG  6'h2f
`define ADLP_RAW_MAX   11'h7ff

`endif

/* File: inc/adlp_pkg.sv */
// Types and small decode helpers of the converter control
// Assumes the map header is included by each user
package adlp_pkg;

    typedef enum logic [1:0] {ST_OFF, ST_SAMPLE, ST_CONVERT} adlp_state_e;

    // Channel code that switches the converter off
    function automatic logic ch_off(input logic [4:0] ch);
        return ch == 5'h1f;
    endfunction

    // Half-LSB rounding with saturation at the top code
    function automatic logic [9:0] round_code(input logic [10:0] raw);
        logic [11:0] s;
        s = {1'b0, raw} + 12'h001;
        return (s[11]) ? 10'h3ff : s[10:1];
    endfunction

endpackage

/* File: inc/adlp_sar_if.sv */
// Control to approximation engine carrier
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface adlp_sar_if;
    logic       start;
    logic       abort;
    logic       long_smp;
    logic       busy;
    logic       done;
    logic [9:0] result;
    logic [10:0] raw;

    modport ctl (output start, abort, long_smp, input busy, done, result, raw);
    modport eng (input start, abort, long_smp, output busy, done, result, raw);
endinterface

/* File: design/adlp_clkdiv.sv */
// Converter clock divider: half-cycle enable pulses
// Assumes the caller gates run while the converter is idle
`timescale 1ns/1ps
module adlp_clkdiv import adlp_pkg::*; #(
    parameter int            CW   = 12,
    parameter logic [CW-1:0] BASE = 12'h002
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       run,
    input  wire logic [1:0] div,
    output logic            tick_q
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] lim;

    // Stopping the count while idle mirrors the gated clock of the core
    assign lim = CW'((BASE << div) - 1'b1);

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q >= lim) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end
endmodule // adlp_clkdiv

/* File: design/adlp_sar.sv */
// Successive approximation sequencer with sample window
// Assumes tick marks half converter-clock periods, comp_in is a pin
`timescale 1ns/1ps
`include "adlp_map.svh"
module adlp_sar import adlp_pkg::*; (
    input  wire logic   clk,
    input  wire logic   srst,
    input  wire logic   tick,
    input  wire logic   comp_in,
    adlp_sar_if.eng     ifc,
    output logic        sample_q,
    output logic [10:0] dac_q
);
    adlp_state_e st_q;
    logic [5:0]  cnt_q;
    logic [3:0]  bit_q;
    logic        ph_q;
    logic        cmp_s1;
    logic        cmp_s2;
    logic [5:0]  lim;
    logic [10:0] keep;

    assign lim      = ifc.long_smp ? `ADLP_SMP_LONG - 6'h01 : `ADLP_SMP_SHORT - 6'h01; // RL1
    assign ifc.busy = (st_q != ST_OFF);
    assign ifc.raw  = keep;
    assign keep     = cmp_s2 ? dac_q : (dac_q & ~(11'h001 << bit_q));

    always_ff @(posedge clk) begin
        cmp_s1 <= comp_in;
        cmp_s2 <= cmp_s1;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        ifc.done <= 1'b0;
        if (srst) begin
            st_q       <= ST_OFF;
            cnt_q      <= 6'h00;
            bit_q      <= 4'h0;
            ph_q       <= 1'b0;
            dac_q      <= 11'h000;
            sample_q   <= 1'b0;
            ifc.result <= 10'h000;
        end else if (ifc.start) begin
            st_q     <= ST_SAMPLE;
            cnt_q    <= 6'h00;
            sample_q <= 1'b1;
        end else if (ifc.abort) begin
            st_q     <= ST_OFF; // RL7
            sample_q <= 1'b0;
        end else if (tick) begin
            unique case (st_q)
                ST_OFF: ;
                ST_SAMPLE: begin
                    if (cnt_q == lim) begin // RL1
                        st_q     <= ST_CONVERT;
                        sample_q <= 1'b0;
                        bit_q    <= 4'ha;
                        ph_q     <= 1'b0;
                        dac_q    <= 11'h400;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                ST_CONVERT: begin
                    ph_q <= !ph_q;
                    if (ph_q) begin
                        if (bit_q == 4'h0) begin
                            st_q       <= ST_OFF; // RL6
                            dac_q      <= keep;
                            ifc.result <= round_code(keep); // RL2
                            ifc.done   <= 1'b1;
                        end else begin
                            bit_q <= bit_q - 4'h1;
                            dac_q <= keep | (11'h001 << (bit_q - 4'h1));
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_SAMPLE_LEN: assert property (@(posedge clk) disable iff (srst) // RL1
        st_q == ST_SAMPLE && tick && !ifc.start && !ifc.abort && cnt_q != lim
        |=> st_q == ST_SAMPLE)
        else $error("sample window ended early");
    AST_ROUND_SAT: assert property (@(posedge clk) disable iff (srst) // RL2
        ifc.done && dac_q == `ADLP_RAW_MAX |-> ifc.result == 10'h3ff)
        else $error("top code not saturated");
    CV_LONG: cover property (@(posedge clk) ifc.long_smp && ifc.done);
endmodule // adlp_sar

/* File: verif/adlp_src.sv */
// Analog source model: ideal input level compared against the trial code
// Assumes DAC and ANALOG_ON come from the converter control top module
`timescale 1ns/1ps
module adlp_src (
    input  wire logic        clk,
    input  wire logic        on,
    input  wire logic [10:0] dac,
    input  wire logic [10:0] vin,
    output logic             comp
);
    logic tgl_q = 1'b0;

    // Unpowered array gives no valid comparison, so toggle instead of hold
    always @(posedge clk) tgl_q <= ~tgl_q;
    assign comp = on ? (vin >= dac) : tgl_q;
endmodule // adlp_src

/* File: verif/test_adc_lowpower_interrupt_control.sv */
// Self-checking bench of the converter control top
// Assumes the analog source model stands on the comparator pin
`timescale 1ns/1ps
module test_adc_lowpower_interrupt_control;
    localparam int SHORT_N = 7 * 2;
    localparam int LONG_N  = 47 * 2;

    logic        mclk, srst, wr, rd, wait_mode, stop_mode, hw_trig, comp;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [10:0] dac, vin;
    logic        irq, sample, analog_on, isolate, rd_q;
    logic [4:0]  ch_sel;
    logic [9:0]  last_code;
    logic [15:0] note, note_list[$];
    int          err_count, total_checks, cyc, n;

    adlp_top #(.DIV_BASE(12'h002)) uut (.MCLK(mclk), .SRST(srst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
        .WAIT_MODE(wait_mode), .STOP_MODE(stop_mode), .HW_TRIG(hw_trig), .COMP(comp),
        .DAC(dac), .SAMPLE(sample), .ANALOG_ON(analog_on), .CH_SEL(ch_sel),
        .ISOLATE(isolate));
    adlp_src src (.clk(mclk), .on(analog_on), .dac(dac), .vin(vin), .comp(comp));

    // ----------------------------------------
    // Clock, timeout, verdict
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs under two thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // ----------------------------------------
    // Read data watcher: oldest note against the cycle after a read
    // ----------------------------------------
    always @(posedge mclk) begin
        if (rd_q && note_list.size() > 0) begin
            note = note_list.pop_front();
            chk("rdata", {8'h00, note[7:0] & note[15:8]}, {8'h00, rdata & note[15:8]});
        end
        rd_q <= rd;
    end

    // ----------------------------------------
    // Register bus tasks
    // ----------------------------------------
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    // Mask picks the bits that matter; zero bits are not compared
    task automatic rreg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        note_list.push_back({m, e});
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic waitfor(input bit w_irq, input logic v, input int lim);
        int k;
        k = 0;
        while (((w_irq ? irq : analog_on) !== v) && k < lim) begin
            @(posedge mclk);
            k++;
        end
        chk(w_irq ? "irq" : "analog_on", 16'(v), 16'((w_irq ? irq : analog_on)));
    endtask

    function automatic logic [9:0] code_of(input logic [10:0] v);
        return (v == 11'h7ff) ? 10'h3ff : 10'((v + 11'h001) >> 1);
    endfunction

    // ----------------------------------------
    // Conversion helpers
    // ----------------------------------------
    task automatic finish(input logic [10:0] v);
        logic [9:0] c;
        c = code_of(v);
        waitfor(1'b1, 1'b1, 400);
        repeat (5) @(posedge mclk);
        chk("irq held", 16'h1, 16'(irq));
        chk("dac", 16'(v), 16'(dac));
        rreg(3'h0, 8'h80, 8'h80);
        rreg(3'h2, {6'h00, c[9:8]}, 8'h03);
        rreg(3'h3, c[7:0], 8'hff);
        rreg(3'h0, 8'h00, 8'h80);
        waitfor(1'b1, 1'b0, 4);
        last_code = c;
    endtask

    task automatic conv(input logic [10:0] v, input logic [7:0] sc);
        vin <= v;
        wreg(3'h0, sc);
        finish(v);
    endtask

    task automatic smp_len(input logic [7:0] sc);
        int k;
        k = 0;
        n = 0;
        wreg(3'h0, sc);
        while (sample !== 1'b1 && k < 10) begin
            @(posedge mclk);
            k++;
        end
        while (sample === 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 3'h0; wdata = 8'h00;
        wait_mode = 1'b0; stop_mode = 1'b0; hw_trig = 1'b0; vin = 11'h000;
        rd_q = 1'b0; err_count = 0; total_checks = 0; cyc = 0;
        void'($urandom(32'hd1b1));
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chk("isolate", 16'h1, 16'(isolate));
        chk("ch_sel", 16'h1f, 16'(ch_sel));
        rreg(3'h0, 8'h1f, 8'hff);
        wreg(3'h6, 8'hff);
        rreg(3'h6, 8'h00, 8'hff);
        // Rounding at both ends of the range plus random levels
        conv(11'h000, 8'h45);
        conv(11'h001, 8'h45);
        conv(11'h002, 8'h45);
        conv(11'h7fe, 8'h45);
        conv(11'h7ff, 8'h45);
        repeat (3) conv(11'($urandom), 8'h45);
        chk("ch_sel", 16'h05, 16'(ch_sel));
        // Sample window lengths, interrupt disabled
        vin <= 11'($urandom);
        smp_len(8'h05);
        chk("short window", 16'h1, 16'(n >= SHORT_N && n <= SHORT_N + 2));
        waitfor(1'b0, 1'b0, 200);
        rreg(3'h0, 8'h80, 8'h80);
        chk("irq off", 16'h0, 16'(irq));
        wreg(3'h1, 8'h01);
        smp_len(8'h05);
        chk("long window", 16'h1, 16'(n >= LONG_N && n <= LONG_N + 2));
        waitfor(1'b0, 1'b0, 300);
        wreg(3'h1, 8'h00);
        // Control write in mid conversion aborts and restarts
        vin <= 11'h155;
        wreg(3'h0, 8'h45);
        repeat (20) @(posedge mclk);
        wreg(3'h0, 8'h45);
        rreg(3'h0, 8'h45, 8'hff);
        finish(11'h155);
        // Channel all ones switches off at once
        wreg(3'h0, 8'h45);
        repeat (20) @(posedge mclk);
        wreg(3'h0, 8'h5f);
        waitfor(1'b0, 1'b0, 4);
        chk("isolate", 16'h1, 16'(isolate));
        // Continuous runs on, then cleared before wait
        vin <= 11'h2aa;
        wreg(3'h0, 8'h65);
        finish(11'h2aa);
        finish(11'h2aa);
        wreg(3'h0, 8'h45);
        wait_mode <= 1'b1;
        finish(11'h2aa);
        wait_mode <= 1'b0;
        waitfor(1'b0, 1'b0, 10);
        // Stop without async clock: abort, masked status, no restart
        wreg(3'h5, 8'h02);
        vin <= 11'h0f0;
        wreg(3'h0, 8'h45);
        repeat (20) @(posedge mclk);
        stop_mode <= 1'b1;
        waitfor(1'b0, 1'b0, 5);
        waitfor(1'b1, 1'b1, 5);
        rreg(3'h4, 8'h02, 8'h02);
        stop_mode <= 1'b0;
        repeat (200) @(posedge mclk);
        chk("analog_on", 16'h0, 16'(analog_on));
        rreg(3'h0, 8'h00, 8'h80);
        rreg(3'h3, last_code[7:0], 8'hff);
        wreg(3'h4, 8'h02);
        rreg(3'h4, 8'h00, 8'h02);
        chk("irq clear", 16'h0, 16'(irq));
        wreg(3'h5, 8'h00);
        conv(11'h0f0, 8'h45);
        // Stop with async clock keeps converting
        wreg(3'h1, 8'h02);
        stop_mode <= 1'b1;
        conv(11'($urandom), 8'h45);
        // Trigger mode in stop idles until the trigger
        wreg(3'h1, 8'h06);
        vin <= 11'h3c3;
        wreg(3'h0, 8'h45);
        repeat (30) @(posedge mclk);
        chk("analog_on", 16'h0, 16'(analog_on));
        hw_trig <= 1'b1;
        repeat (3) @(posedge mclk);
        hw_trig <= 1'b0;
        finish(11'h3c3);
        stop_mode <= 1'b0;
        wreg(3'h1, 8'h00);
        give_verdict();
    end
endmodule // test_adc_lowpower_interrupt_control
